//--- common/asm_cfg.svh
`ifndef ASM_CFG_SVH
`define ASM_CFG_SVH

// register offsets on the control port
`define ASM_ADDR_PWR_RST   8'h6b
`define ASM_ADDR_MUTE      8'h6c
`define ASM_ADDR_SHORT     8'h6d
`define ASM_ADDR_LDIFF     8'h6e
`define ASM_ADDR_RDIFF     8'h6f
`define ASM_ADDR_LSIGN     8'h70

// field positions and widths
`define ASM_MUTE_DUMMY_L   5
`define ASM_MUTE_DUMMY_R   4
`define ASM_MUTE_ANALOG_L  1
`define ASM_MUTE_ANALOG_R  0
`define ASM_SHORT_LIVE     4
`define ASM_SHORT_LATCHED  0
`define ASM_LSIGN_SIGN     7
`define ASM_CMFB_WIDTH     5
`define ASM_DIFF_WIDTH     8

// writable reserved storage masks
`define ASM_MUTE_RSV_MASK  8'hcc
`define ASM_SHORT_RSV_MASK 8'hee
`define ASM_LSIGN_RSV_MASK 8'h60

// reset values and unmapped read data
`define ASM_RSV_RESET      8'h00
`define ASM_RDATA_RESET    8'h00
`define ASM_UNMAPPED_DATA  8'h00

// pin filter depth in flip-flops
`define ASM_SYNC_STAGES    3

`endif

//--- common/asm_pkg.sv
package asm_pkg;

  typedef struct packed {
    logic offset_comp_power_state;
    logic short_protector_power_state;
    logic impedance_sense_power_state;
    logic impedance_whole_power_state;
    logic left_short_prot_reset_state;
    logic right_short_prot_reset_state;
    logic dac_modulator_reset_state;
    logic dac_element_match_reset_state;
  } asm_pwr_rst_t;

  typedef struct packed {
    logic left_dummy_mute_state;
    logic right_dummy_mute_state;
    logic left_analog_mute_state;
    logic right_analog_mute_state;
  } asm_mute_t;

  typedef struct packed {
    logic       left_offset_sign;
    logic [4:0] left_cmfb_offset_value;
    logic [7:0] left_diff_offset_value;
    logic [7:0] right_diff_offset_value;
  } asm_offset_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } asm_reg_req_t;

  typedef struct packed {
    logic       rvalid;
    logic       err;
    logic [7:0] rdata;
  } asm_reg_rsp_t;

  typedef enum logic [1:0] {
    ASM_CAL_IDLE = 2'b00,
    ASM_CAL_RUN  = 2'b01,
    ASM_CAL_HOLD = 2'b11
  } asm_cal_state_t;

endpackage

//--- core/asm_pin_sync.sv
`timescale 1ns/100ps
`default_nettype none

module asm_pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] pin_in,
  output var  logic [WIDTH-1:0] pin_out
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] agree;

  // s1 feeds s2 only; nothing else looks at the metastable stage
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  assign agree = ~(s2_reg ^ s3_reg);

  // a bit moves only once the second and third stages agree
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pin_out <= '0;
    end else begin
      pin_out <= (s2_reg & agree) | (pin_out & ~agree);
    end
  end

endmodule

`default_nettype wire

//--- core/asm_offset_hold.sv
`timescale 1ns/100ps
`default_nettype none

module asm_offset_hold (
  input  wire logic                 ref_clk,
  input  wire logic                 resetn,
  input  wire logic                 cal_active,
  input  wire asm_pkg::asm_offset_t cal_value,
  output var  asm_pkg::asm_offset_t held_value,
  output var  logic                 cal_settled
);

  asm_pkg::asm_cal_state_t state_reg;
  asm_pkg::asm_cal_state_t state_next;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      asm_pkg::ASM_CAL_IDLE: if (cal_active) state_next = asm_pkg::ASM_CAL_RUN;
      asm_pkg::ASM_CAL_RUN:  if (!cal_active) state_next = asm_pkg::ASM_CAL_HOLD;
      asm_pkg::ASM_CAL_HOLD: if (cal_active) state_next = asm_pkg::ASM_CAL_RUN;
      default:               state_next = asm_pkg::ASM_CAL_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= asm_pkg::ASM_CAL_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // values follow the compensator while it runs and freeze when it ends
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      held_value <= '0;
    end else if (cal_active) begin
      held_value <= cal_value;
    end
  end

  assign cal_settled = (state_reg == asm_pkg::ASM_CAL_HOLD);

endmodule

`default_nettype wire

//--- core/asm_status_monitor_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "asm_cfg.svh"

module asm_status_monitor_regs (
  input  wire logic                  ref_clk,
  input  wire logic                  resetn,
  input  wire asm_pkg::asm_pwr_rst_t pwr_rst_pins,
  input  wire asm_pkg::asm_mute_t    mute_pins,
  input  wire logic                  live_short_pin,
  input  wire logic                  cal_active,
  input  wire asm_pkg::asm_offset_t  cal_value,
  input  wire asm_pkg::asm_reg_req_t reg_req,
  output var  asm_pkg::asm_reg_rsp_t reg_rsp,
  output var  logic                  cal_settled
);

////////////////////////////////////////////////////////////////////////////////

  asm_pkg::asm_pwr_rst_t pwr_rst_sync;
  asm_pkg::asm_mute_t    mute_sync;
  logic                  live_short_sync;
  asm_pkg::asm_offset_t  offset_held;

  logic [7:0] mute_rsv_reg;
  logic [7:0] short_rsv_reg;
  logic [7:0] lsign_rsv_reg;
  logic       latched_short_flag_reg;
  logic       latched_short_flag_next;

  logic       rd_short;
  logic       wr_mute;
  logic       wr_short;
  logic       wr_lsign;
  logic       addr_hit;
  logic [7:0] rdata_next;

////////////////////////////////////////////////////////////////////////////////
// address decode and read assembly

  function automatic logic known_addr(input logic [7:0] a);
    unique case (a)
      `ASM_ADDR_PWR_RST,
      `ASM_ADDR_MUTE,
      `ASM_ADDR_SHORT,
      `ASM_ADDR_LDIFF,
      `ASM_ADDR_RDIFF,
      `ASM_ADDR_LSIGN: known_addr = 1'b1;
      default:         known_addr = 1'b0;
    endcase
  endfunction

  // merges live read-only bits with reserved storage under a mask
  function automatic logic [7:0] merge_rsv(
    input logic [7:0] live,
    input logic [7:0] rsv,
    input logic [7:0] mask
  );
    merge_rsv = (live & ~mask) | (rsv & mask);
  endfunction

  function automatic logic [7:0] keep_rsv(
    input logic [7:0] old,
    input logic [7:0] wdata,
    input logic [7:0] mask
  );
    keep_rsv = wdata & mask;
    if (mask == 8'h00) begin
      keep_rsv = old;
    end
  endfunction

////////////////////////////////////////////////////////////////////////////////
// status inputs arrive from analog and power control, outside this clock

  asm_pin_sync #(
    .WIDTH ($bits(asm_pkg::asm_pwr_rst_t))
  ) u_pwr_rst_sync (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .pin_in  (pwr_rst_pins),
    .pin_out (pwr_rst_sync)
  );

  asm_pin_sync #(
    .WIDTH ($bits(asm_pkg::asm_mute_t))
  ) u_mute_sync (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .pin_in  (mute_pins),
    .pin_out (mute_sync)
  );

  asm_pin_sync #(
    .WIDTH (1)
  ) u_short_sync (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .pin_in  (live_short_pin),
    .pin_out (live_short_sync)
  );

////////////////////////////////////////////////////////////////////////////////
// offset compensator results; calibration logic runs on ref_clk

  asm_offset_hold u_offset_hold (
    .ref_clk     (ref_clk),
    .resetn      (resetn),
    .cal_active  (cal_active),
    .cal_value   (cal_value),
    .held_value  (offset_held),
    .cal_settled (cal_settled)
  );

////////////////////////////////////////////////////////////////////////////////
// strobes

  assign addr_hit = known_addr(reg_req.addr);
  assign rd_short = reg_req.rd && (reg_req.addr == `ASM_ADDR_SHORT);
  assign wr_mute  = reg_req.wr && (reg_req.addr == `ASM_ADDR_MUTE);
  assign wr_short = reg_req.wr && (reg_req.addr == `ASM_ADDR_SHORT);
  assign wr_lsign = reg_req.wr && (reg_req.addr == `ASM_ADDR_LSIGN);

////////////////////////////////////////////////////////////////////////////////
// reserved storage; only masked bits take a write, the rest is dropped

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mute_rsv_reg <= `ASM_RSV_RESET;
    end else if (wr_mute) begin
      mute_rsv_reg <= keep_rsv(mute_rsv_reg, reg_req.wdata, `ASM_MUTE_RSV_MASK);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      short_rsv_reg <= `ASM_RSV_RESET;
    end else if (wr_short) begin
      short_rsv_reg <= keep_rsv(short_rsv_reg, reg_req.wdata, `ASM_SHORT_RSV_MASK);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      lsign_rsv_reg <= `ASM_RSV_RESET;
    end else if (wr_lsign) begin
      lsign_rsv_reg <= keep_rsv(lsign_rsv_reg, reg_req.wdata, `ASM_LSIGN_RSV_MASK);
    end
  end

////////////////////////////////////////////////////////////////////////////////
// sticky short flag: a short in the clearing cycle survives the read

  always_comb begin
    latched_short_flag_next = latched_short_flag_reg;
    if (rd_short) begin
      latched_short_flag_next = 1'b0;
    end
    if (live_short_sync) begin
      latched_short_flag_next = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      latched_short_flag_reg <= 1'b0;
    end else begin
      latched_short_flag_reg <= latched_short_flag_next;
    end
  end

////////////////////////////////////////////////////////////////////////////////
// read mux; reading touches nothing but the sticky flag

  always_comb begin
    rdata_next = `ASM_UNMAPPED_DATA;
    unique case (reg_req.addr)
      `ASM_ADDR_PWR_RST: begin
        rdata_next = pwr_rst_sync;
      end
      `ASM_ADDR_MUTE: begin
        rdata_next = merge_rsv(8'h00, mute_rsv_reg, `ASM_MUTE_RSV_MASK);
        rdata_next[`ASM_MUTE_DUMMY_L]  = mute_sync.left_dummy_mute_state;
        rdata_next[`ASM_MUTE_DUMMY_R]  = mute_sync.right_dummy_mute_state;
        rdata_next[`ASM_MUTE_ANALOG_L] = mute_sync.left_analog_mute_state;
        rdata_next[`ASM_MUTE_ANALOG_R] = mute_sync.right_analog_mute_state;
      end
      `ASM_ADDR_SHORT: begin
        rdata_next = merge_rsv(8'h00, short_rsv_reg, `ASM_SHORT_RSV_MASK);
        rdata_next[`ASM_SHORT_LIVE]    = live_short_sync;
        rdata_next[`ASM_SHORT_LATCHED] = latched_short_flag_reg;
      end
      `ASM_ADDR_LDIFF: begin
        rdata_next = offset_held.left_diff_offset_value;
      end
      `ASM_ADDR_RDIFF: begin
        rdata_next = offset_held.right_diff_offset_value;
      end
      `ASM_ADDR_LSIGN: begin
        rdata_next = merge_rsv(8'h00, lsign_rsv_reg, `ASM_LSIGN_RSV_MASK);
        rdata_next[`ASM_LSIGN_SIGN] = offset_held.left_offset_sign;
        rdata_next[`ASM_CMFB_WIDTH-1:0] = offset_held.left_cmfb_offset_value;
      end
      default: begin
        rdata_next = `ASM_UNMAPPED_DATA;
      end
    endcase
  end

  // reset state bits pass straight through; 0 means held in reset

////////////////////////////////////////////////////////////////////////////////
// answer: one cycle after the request, data from flip-flops

  // one process owns the whole response word; unmapped access is flagged, never stored
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rsp.rdata  <= `ASM_RDATA_RESET;
      reg_rsp.rvalid <= 1'b0;
      reg_rsp.err    <= 1'b0;
    end else begin
      if (reg_req.rd) begin
        reg_rsp.rdata <= rdata_next;
      end
      reg_rsp.rvalid <= reg_req.rd;
      reg_rsp.err    <= (reg_req.rd || reg_req.wr) && !addr_hit;
    end
  end

endmodule

`default_nettype wire

//--- tb/asm_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module asm_host_model (
  input  wire logic                  ref_clk,
  input  wire logic                  resetn,
  input  wire asm_pkg::asm_reg_req_t cmd,
  output var  asm_pkg::asm_reg_req_t reg_req
);
  // a command lasts one edge, so strobes never stretch into a second access
  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn) reg_req <= '0;
    else reg_req <= cmd;
endmodule
`default_nettype wire

//--- tb/asm_status_monitor_regs_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module asm_status_monitor_regs_asserts (
  input  wire logic                  ref_clk,
  input  wire logic                  resetn,
  input  wire asm_pkg::asm_pwr_rst_t pwr_rst_pins,
  input  wire asm_pkg::asm_mute_t    mute_pins,
  input  wire logic                  live_short_pin,
  input  wire logic                  cal_active,
  input  wire asm_pkg::asm_offset_t  cal_value,
  input  wire asm_pkg::asm_reg_req_t reg_req,
  input  wire asm_pkg::asm_reg_rsp_t reg_rsp,
  input  wire logic                  cal_settled
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // pin filters restart at reset, so mirrors are only judged once they refill
  logic [2:0] up_reg;
  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn) up_reg <= 3'h0;
    else if (up_reg != 3'h7) up_reg <= up_reg + 3'h1;
  wire logic rd_up = reg_req.rd && up_reg == 3'h7;
  wire logic [7:0] ra = reg_req.addr;
  ////////////////////////////////////////////////////////////
  property p_rd_ack; reg_req.rd |=> reg_rsp.rvalid; endproperty
  a_rd_ack: assert property (p_rd_ack) else $error("read not answered");
  property p_unmapped; reg_req.rd && (ra < 8'h6b || ra > 8'h70) |=> reg_rsp.err && reg_rsp.rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not flagged");
  property p_mapped; reg_req.rd && ra inside {[8'h6b:8'h70]} |=> !reg_rsp.err; endproperty
  a_mapped: assert property (p_mapped) else $error("mapped read flagged");
  property p_pwr; $stable(pwr_rst_pins)[*5] ##0 (rd_up && ra == 8'h6b) |=> reg_rsp.rdata == $past(pwr_rst_pins); endproperty
  a_pwr: assert property (p_pwr) else $error("power monitor mismatch");
  property p_mute; $stable(mute_pins)[*5] ##0 (rd_up && ra == 8'h6c) |=> {reg_rsp.rdata[5:4], reg_rsp.rdata[1:0]} == $past(mute_pins); endproperty
  a_mute: assert property (p_mute) else $error("mute monitor mismatch");
  property p_live; $stable(live_short_pin)[*5] ##0 (rd_up && ra == 8'h6d) |=> reg_rsp.rdata[4] == $past(live_short_pin); endproperty
  a_live: assert property (p_live) else $error("live short mismatch");
  property p_stk_set; live_short_pin[*6] ##0 (rd_up && ra == 8'h6d) |=> reg_rsp.rdata[0]; endproperty
  a_stk_set: assert property (p_stk_set) else $error("sticky short not set");
  property p_stk_clr; (!live_short_pin)[*7] ##0 (rd_up && ra == 8'h6d) ##1 (rd_up && ra == 8'h6d) |=> !reg_rsp.rdata[0]; endproperty
  a_stk_clr: assert property (p_stk_clr) else $error("sticky short not cleared");
  property p_hold; cal_settled && !cal_active |=> cal_settled; endproperty
  a_hold: assert property (p_hold) else $error("settled dropped");
  c_err: cover property (reg_rsp.err);
  c_stk: cover property (reg_rsp.rvalid && reg_rsp.rdata[0]);
  c_cal: cover property ($rose(cal_settled));
endmodule
bind asm_status_monitor_regs asm_status_monitor_regs_asserts u_asm_status_monitor_regs_asserts (
  .ref_clk(ref_clk), .resetn(resetn), .pwr_rst_pins(pwr_rst_pins), .mute_pins(mute_pins),
  .live_short_pin(live_short_pin), .cal_active(cal_active), .cal_value(cal_value),
  .reg_req(reg_req), .reg_rsp(reg_rsp), .cal_settled(cal_settled));
`default_nettype wire

//--- tb/tb_amp_status_monitor_regs.sv
`timescale 1ns/100ps
`default_nettype none
module tb_amp_status_monitor_regs;
  logic ref_clk, resetn, live, cal_act, settled, stk;
  asm_pkg::asm_pwr_rst_t pwr;
  asm_pkg::asm_mute_t mute;
  asm_pkg::asm_offset_t cal_val, cal_x;
  asm_pkg::asm_reg_req_t cmd, req;
  asm_pkg::asm_reg_rsp_t rsp;
  logic [7:0] rs_m, rs_s, rs_g;
  logic [8:0] exp_q[$];
  logic [8:0] e;
  logic [31:0] seed = 32'hb19e63fd;
  int err_total, total_checks;
  asm_host_model u_asm_host_model (.ref_clk(ref_clk), .resetn(resetn), .cmd(cmd), .reg_req(req));
  asm_status_monitor_regs u_asm_status_monitor_regs (.ref_clk(ref_clk), .resetn(resetn),
    .pwr_rst_pins(pwr), .mute_pins(mute), .live_short_pin(live), .cal_active(cal_act),
    .cal_value(cal_val), .reg_req(req), .reg_rsp(rsp), .cal_settled(settled));
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  function automatic logic [7:0] model(input logic [7:0] a);
    case (a)
      8'h6b: return pwr;
      8'h6c: return rs_m | {2'h0, mute[3:2], 2'h0, mute[1:0]};
      8'h6d: return rs_s | {3'h0, live, 3'h0, stk};
      8'h6e: return cal_x.left_diff_offset_value;
      8'h6f: return cal_x.right_diff_offset_value;
      8'h70: return rs_g | {cal_x.left_offset_sign, 2'h0, cal_x.left_cmfb_offset_value};
      default: return 8'h00;
    endcase
  endfunction
  task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d);
    cmd <= '{rd: ~w, wr: w, addr: a, wdata: d};
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    exp_q.push_back({a < 8'h6b || a > 8'h70, model(a)});
    op(1'b0, a, 8'h00);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a == 8'h6c) rs_m = d & 8'hcc;
    if (a == 8'h6d) rs_s = d & 8'hee;
    if (a == 8'h70) rs_g = d & 8'h60;
    op(1'b1, a, d);
  endtask
  task automatic wt(input int n);
    cmd <= '0;
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic results;
    err_total += exp_q.size();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    #100000;
    err_total++;
    results();
  end
  // responses are taken off the queue in request order, one per rvalid
  initial forever begin
    @(posedge ref_clk);
    #1;
    if (rsp.rvalid === 1'b1) begin
      e = exp_q.size() ? exp_q.pop_front() : 9'h1ff;
      total_checks++;
      if ({rsp.err, rsp.rdata} !== e) begin
        err_total++;
        $display("wrong value t=%0t got %h exp %h", $time, {rsp.err, rsp.rdata}, e);
      end
    end
  end
  initial begin
    {resetn, live, cal_act, stk} = 4'h0;
    {pwr, mute, cal_val, cal_x, cmd} = '0;
    {rs_m, rs_s, rs_g} = '0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    wt(1);
    for (int a = 8'h6a; a <= 8'h71; a++) rd(a[7:0]);
    repeat (6) begin
      seed = xs(seed);
      pwr <= seed[7:0];
      mute <= seed[11:8];
      wt(8);
      rd(8'h6b);
      rd(8'h6c);
      wr(8'h6b, seed[23:16]);
      wr(8'h6c, seed[31:24]);
      rd(8'h6b);
      rd(8'h6c);
      wt(1);
    end
    wr(8'h6d, 8'hff);
    live <= 1'b1;
    stk = 1'b1;
    wt(8);
    rd(8'h6d);
    rd(8'h6d);
    live <= 1'b0;
    wt(8);
    rd(8'h6d);
    stk = 1'b0;
    rd(8'h6d);
    seed = xs(seed);
    cal_act <= 1'b1;
    cal_val <= seed[21:0];
    cal_x = seed[21:0];
    wt(2);
    seed = xs(seed);
    cal_act <= 1'b0;
    cal_val <= seed[21:0];
    wt(3);
    total_checks++;
    if (settled !== 1'b1) begin
      err_total++;
      $display("wrong value t=%0t settled low", $time);
    end
    wr(8'h70, 8'hff);
    wr(8'h6e, 8'h5a);
    for (int a = 8'h6e; a <= 8'h70; a++) rd(a[7:0]);
    wt(4);
    results();
  end
endmodule
`default_nettype wire
